//--- asq_seq.sv
// Acquisition start trigger sequencer: gates frame start triggers behind acq start.
// Assumes synchronous line inputs, one clock, register port with one-cycle read latency.
`timescale 1ns/1ps
module asq_seq (
    input wire logic I_MCLK,
    input wire logic I_RESET,
    input wire logic I_CE,
    input wire logic [asq_pkg::ADDR_W-1:0] I_ADDR,
    input wire logic [asq_pkg::DATA_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [asq_pkg::DATA_W-1:0] O_RDATA,
    input wire logic I_LINE1,
    input wire logic I_LINE2,
    input wire logic I_FRAME_TRIG,
    output logic O_FRAME_ACCEPT,
    output logic O_WAITING_ACQ,
    output logic O_WAITING_FRAME
);
    asq_pkg::asq_state_t state_reg, state_next;
    logic [5:0] ctrl_reg;
    logic [7:0] frames_reg;
    logic [23:0] delay_reg;
    logic [23:0] us_left_reg;
    logic [4:0] tick_reg;
    logic [7:0] fcnt_reg;
    logic line_prev_reg;
    logic armed_reg;
    logic [asq_pkg::DATA_W-1:0] rdata_reg;
    asq_pkg::asq_cfg_t cfg;
    assign cfg.mode_on = ctrl_reg[asq_pkg::CTRL_MODE_ON];
    assign cfg.src = ctrl_reg[asq_pkg::CTRL_SRC_LO +: 2];
    assign cfg.rising = ctrl_reg[asq_pkg::CTRL_RISING];
    assign cfg.single = ctrl_reg[asq_pkg::CTRL_SINGLE];
    wire sel_acq = ctrl_reg[asq_pkg::CTRL_SEL_ACQ];
    wire wr_ctrl = I_WR && (I_ADDR == asq_pkg::OFS_CTRL);
    wire wr_frames = I_WR && (I_ADDR == asq_pkg::OFS_FRAMES);
    wire wr_delay = I_WR && (I_ADDR == asq_pkg::OFS_DELAY) && sel_acq;
    wire wr_cmd = I_WR && (I_ADDR == asq_pkg::OFS_CMD);
    wire cmd_start = wr_cmd && I_WDATA[asq_pkg::CMD_START];
    wire cmd_stop = wr_cmd && I_WDATA[asq_pkg::CMD_STOP];
    wire soft_trig = wr_cmd && I_WDATA[asq_pkg::CMD_SOFT] && sel_acq && (cfg.src == asq_pkg::SRC_SOFT);
    wire line_sel = (cfg.src == asq_pkg::SRC_LINE2) ? I_LINE2 : I_LINE1;
    wire hw_src = (cfg.src == asq_pkg::SRC_LINE1) || (cfg.src == asq_pkg::SRC_LINE2);
    wire edge_hit = hw_src && (cfg.rising ? (line_sel && !line_prev_reg) : (!line_sel && line_prev_reg));
    wire [7:0] frames_wr = (I_WDATA[7:0] < asq_pkg::FRAMES_MIN) ? asq_pkg::FRAMES_MIN : I_WDATA[7:0];
    wire [23:0] delay_wr = (I_WDATA > 32'(asq_pkg::DELAY_MAX_US)) ? asq_pkg::DELAY_MAX_US : I_WDATA[23:0];
    wire [7:0] target = cfg.single ? asq_pkg::FRAMES_MIN : frames_reg;
    wire frame_ok = (state_reg == asq_pkg::ASQ_WAIT_FRAME) && I_FRAME_TRIG;
    wire last_frame = frame_ok && ((fcnt_reg + 8'h01) >= target);
    wire us_tick = (tick_reg == 5'(asq_pkg::CYC_PER_US - 1));
    wire delay_done = (us_left_reg <= 24'h000001) && us_tick;
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            asq_pkg::ASQ_IDLE: begin
                if (armed_reg) begin
                    state_next = cfg.mode_on ? asq_pkg::ASQ_WAIT_ACQ : asq_pkg::ASQ_WAIT_FRAME;
                end
            end
            asq_pkg::ASQ_WAIT_ACQ: begin
                if (!cfg.mode_on) begin
                    state_next = asq_pkg::ASQ_WAIT_FRAME;
                end else if (soft_trig) begin
                    state_next = asq_pkg::ASQ_WAIT_FRAME;
                end else if (edge_hit) begin
                    state_next = (delay_reg == 24'h000000) ? asq_pkg::ASQ_WAIT_FRAME : asq_pkg::ASQ_DELAY;
                end
            end
            asq_pkg::ASQ_DELAY: begin
                if (!cfg.mode_on || delay_done) begin
                    state_next = asq_pkg::ASQ_WAIT_FRAME;
                end
            end
            asq_pkg::ASQ_WAIT_FRAME: begin
                if (last_frame) begin
                    state_next = cfg.mode_on ? asq_pkg::ASQ_WAIT_ACQ : asq_pkg::ASQ_WAIT_FRAME;
                end
            end
            default: begin
                state_next = asq_pkg::ASQ_IDLE;
            end
        endcase
        if (!armed_reg) begin
            state_next = asq_pkg::ASQ_IDLE;
        end
    end
    wire enter_frame = (state_next == asq_pkg::ASQ_WAIT_FRAME) && (state_reg != asq_pkg::ASQ_WAIT_FRAME);
    wire rearm_frame = last_frame && (state_next == asq_pkg::ASQ_WAIT_FRAME);
    always_ff @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            state_reg <= asq_pkg::ASQ_IDLE;
            armed_reg <= 1'b0;
            line_prev_reg <= 1'b0;
        end else if (I_CE) begin
            state_reg <= state_next;
            armed_reg <= cmd_start ? 1'b1 : (cmd_stop ? 1'b0 : armed_reg);
            line_prev_reg <= line_sel;
        end
    end
    always_ff @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            ctrl_reg <= asq_pkg::CTRL_RESET;
            frames_reg <= asq_pkg::FRAMES_RESET;
            delay_reg <= 24'h000000;
        end else if (I_CE) begin
            ctrl_reg <= wr_ctrl ? I_WDATA[5:0] : ctrl_reg;
            frames_reg <= wr_frames ? frames_wr : frames_reg;
            delay_reg <= wr_delay ? delay_wr : delay_reg;
        end
    end
    always_ff @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            us_left_reg <= 24'h000000;
            tick_reg <= 5'h00;
        end else if (I_CE) begin
            if (state_reg != asq_pkg::ASQ_DELAY) begin
                us_left_reg <= delay_reg;
                tick_reg <= 5'h00;
            end else begin
                tick_reg <= us_tick ? 5'h00 : tick_reg + 5'h01;
                us_left_reg <= us_tick ? us_left_reg - 24'h000001 : us_left_reg;
            end
        end
    end
    always_ff @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            fcnt_reg <= 8'h00;
        end else if (I_CE) begin
            if (enter_frame || rearm_frame) begin
                fcnt_reg <= 8'h00;
            end else if (frame_ok) begin
                fcnt_reg <= fcnt_reg + 8'h01;
            end
        end
    end
    wire [asq_pkg::DATA_W-1:0] rd_mux =
        (I_ADDR == asq_pkg::OFS_CTRL) ? {26'h0, ctrl_reg} :
        (I_ADDR == asq_pkg::OFS_FRAMES) ? {24'h0, frames_reg} :
        (I_ADDR == asq_pkg::OFS_DELAY) ? {8'h0, delay_reg} :
        (I_ADDR == asq_pkg::OFS_CMD) ? {20'h0, fcnt_reg, 1'b0, armed_reg, state_reg} : 32'h0;
    always_ff @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            rdata_reg <= 32'h0;
        end else if (I_CE) begin
            rdata_reg <= I_RD ? rd_mux : 32'h0;
        end
    end
    assign O_RDATA = rdata_reg;
    assign O_FRAME_ACCEPT = frame_ok && I_CE;
    assign O_WAITING_ACQ = (state_reg == asq_pkg::ASQ_WAIT_ACQ) || (state_reg == asq_pkg::ASQ_DELAY);
    assign O_WAITING_FRAME = (state_reg == asq_pkg::ASQ_WAIT_FRAME);
endmodule

//--- asq_pkg.sv
// Constants, types and register map of the acquisition start trigger sequencer.
// Assumes a single 25 MHz clock and a plain register port in the including design.
package asq_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_FRAMES = 4'h4;
    localparam logic [3:0] OFS_DELAY = 4'h8;
    localparam logic [3:0] OFS_CMD = 4'hC;
    localparam int CTRL_MODE_ON = 0;
    localparam int CTRL_SRC_LO = 1;
    localparam int CTRL_RISING = 3;
    localparam int CTRL_SINGLE = 4;
    localparam int CTRL_SEL_ACQ = 5;
    localparam int CMD_SOFT = 0;
    localparam int CMD_START = 1;
    localparam int CMD_STOP = 2;
    localparam logic [1:0] SRC_SOFT = 2'h0;
    localparam logic [1:0] SRC_LINE1 = 2'h1;
    localparam logic [1:0] SRC_LINE2 = 2'h2;
    localparam logic [5:0] CTRL_RESET = 6'h21;
    localparam logic [7:0] FRAMES_RESET = 8'h01;
    localparam logic [7:0] FRAMES_MIN = 8'h01;
    localparam logic [23:0] DELAY_MAX_US = 24'h989680;
    localparam int CLK_MHZ = 25;
    localparam int NS_PER_US = 1000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        ASQ_IDLE = 2'b00,
        ASQ_WAIT_ACQ = 2'b01,
        ASQ_DELAY = 2'b11,
        ASQ_WAIT_FRAME = 2'b10
    } asq_state_t;
    typedef struct packed {
        logic single;
        logic rising;
        logic [1:0] src;
        logic mode_on;
    } asq_cfg_t;
endpackage

//--- asq_seq_sva.sv
// Checker of the sequencer's port behaviour.
// Assumes it is bound into asq_seq and sees its clock enable.
`timescale 1ns/1ps
module asq_seq_sva (
    input wire logic I_MCLK,
    input wire logic I_RESET,
    input wire logic I_CE,
    input wire logic [3:0] I_ADDR,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [31:0] O_RDATA,
    input wire logic I_FRAME_TRIG,
    input wire logic O_FRAME_ACCEPT,
    input wire logic O_WAITING_ACQ,
    input wire logic O_WAITING_FRAME
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (I_RESET);
    gate_accept_a: assert property (O_FRAME_ACCEPT |-> O_WAITING_FRAME) else $error("stray accept");
    take_frame_a: assert property (I_FRAME_TRIG && O_WAITING_FRAME && I_CE |-> O_FRAME_ACCEPT)
        else $error("lost frame");
    one_state_a: assert property (!(O_WAITING_ACQ && O_WAITING_FRAME)) else $error("two states");
    frame_entry_a: assert property ($rose(O_WAITING_FRAME) |-> $past(O_WAITING_ACQ) || $past(I_WR, 2))
        else $error("bad entry");
    frame_exit_a: assert property ($fell(O_WAITING_FRAME) |-> $past(O_FRAME_ACCEPT) || $past(I_WR, 2))
        else $error("bad exit");
    frames_read_a: assert property (I_RD && I_ADDR == 4'h4 |=> O_RDATA inside {[1:255]}) else $error("frames");
    delay_read_a: assert property (I_RD && I_ADDR == 4'h8 |=> O_RDATA <= 32'h989680) else $error("delay");
    state_read_a: assert property (I_RD && I_ADDR == 4'hC |=> O_RDATA[0] == $past(O_WAITING_ACQ))
        else $error("state code");
    cover property (O_FRAME_ACCEPT);
    cover property ($fell(O_WAITING_FRAME));
    cover property ($rose(O_WAITING_FRAME));
endmodule
bind asq_seq asq_seq_sva asq_seq_sva_inst (.*);

//--- asq_host.sv
// Host model: plain register bus master used by the bench.
// Assumes one task call at a time, timed by the rising edge of i_clk.
`timescale 1ns/1ps
module asq_host (
    input wire logic i_clk,
    input wire logic [31:0] i_rdata,
    output logic [3:0] o_addr = 4'h0,
    output logic [31:0] o_wdata = 32'h0,
    output logic o_wr = 1'b0,
    output logic o_rd = 1'b0
);
    task bus(input logic w, input logic [3:0] a, input logic [31:0] v, output logic [31:0] d);
        @(posedge i_clk) {o_wr, o_rd, o_addr, o_wdata} <= {w, !w, a, v};
        @(posedge i_clk) {o_wr, o_rd} <= 2'b00;
        #1 d = i_rdata;
    endtask
endmodule

//--- tb_acq_start_trigger_seq.sv
// Bench for the acquisition start trigger sequencer.
// Assumes asq_pkg, asq_seq, the checker and asq_host are compiled first.
`timescale 1ns/1ps
module tb_acq_start_trigger_seq;
    logic wr, rd, acc, wacq, wfrm, I_MCLK = 1'b0, I_RESET = 1'b1;
    logic [2:0] pins = 3'b000;
    logic ce = 1'b1;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, d;
    int num_errors = 0, checks = 0;
    always #20 I_MCLK = ~I_MCLK;
    asq_seq asq_seq_inst (.I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_CE(ce), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_LINE1(pins[0]), .I_LINE2(pins[1]), .I_FRAME_TRIG(pins[2]),
        .O_FRAME_ACCEPT(acc), .O_WAITING_ACQ(wacq), .O_WAITING_FRAME(wfrm));
    asq_host h (.i_clk(I_MCLK), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) $display("unexpected t=%0t seen=%h exp=%h", $time, s, e);
        num_errors += int'(s !== e);
    endtask
    task print_verdict(input int add);
        num_errors += add;
        $display("errors=%0d checks=%0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task t_soft;
        h.bus(1'b1, 4'h8, 32'hFFFFFFFF, d);
        h.bus(1'b0, 4'h8, 32'h0, d);
        chk(d, 32'h989680);
        h.bus(1'b1, 4'h4, 32'h0, d);
        h.bus(1'b0, 4'h4, 32'h0, d);
        chk(d, 32'h1);
        h.bus(1'b1, 4'hC, 32'h2, d);
        @(posedge I_MCLK) pins <= 3'b100;
        #1 chk(acc, 1'b0);
        @(posedge I_MCLK) pins <= 3'b000;
        h.bus(1'b1, 4'hC, 32'h1, d);
        chk(wfrm, 1'b1);
        @(posedge I_MCLK) pins <= 3'b100;
        #1 chk(acc, 1'b1);
        @(posedge I_MCLK) pins <= 3'b000;
        #1 chk(wacq, 1'b1);
    endtask
    task t_hw;
        h.bus(1'b1, 4'h8, 32'h2, d);
        h.bus(1'b1, 4'h0, 32'h2D, d);
        @(posedge I_MCLK) pins <= 3'b001;
        repeat (25) @(posedge I_MCLK);
        h.bus(1'b0, 4'hC, 32'h0, d);
        chk(d & 32'h3, 32'h1);
        @(posedge I_MCLK) pins <= 3'b011;
        repeat (2 * asq_pkg::CYC_PER_US) @(posedge I_MCLK);
        #1 chk(wfrm, 1'b0);
        @(posedge I_MCLK);
        #1 chk(wfrm, 1'b1);
    endtask
    task t_more;
        h.bus(1'b1, 4'h4, 32'h3, d);
        repeat (2) begin
            @(posedge I_MCLK) pins <= 3'b111;
            #1 chk(acc, 1'b1);
            @(posedge I_MCLK) pins <= 3'b011;
        end
        #1 chk(wfrm, 1'b1);
        h.bus(1'b0, 4'hC, 32'h0, d);
        chk(d, 32'h26);
        @(posedge I_MCLK) pins <= 3'b111;
        #1 chk(acc, 1'b1);
        @(posedge I_MCLK) pins <= 3'b011;
        #1 chk(wacq, 1'b1);
        h.bus(1'b1, 4'h8, 32'h0, d);
        @(posedge I_MCLK) pins <= 3'b001;
        #1 chk(wacq, 1'b1);
        @(posedge I_MCLK) pins <= 3'b011;
        #1 chk(wacq, 1'b1);
        @(posedge I_MCLK);
        #1 chk(wfrm, 1'b1);
        h.bus(1'b1, 4'h0, 32'h3D, d);
        @(posedge I_MCLK) pins <= 3'b111;
        #1 chk(acc, 1'b1);
        @(posedge I_MCLK) pins <= 3'b011;
        #1 chk(wacq, 1'b1);
        h.bus(1'b1, 4'h0, 32'h3C, d);
        @(posedge I_MCLK);
        #1 chk(wfrm, 1'b1);
        @(posedge I_MCLK) pins <= 3'b111;
        #1 chk(acc, 1'b1);
        @(posedge I_MCLK) ce <= 1'b0;
        #1 chk(wfrm, 1'b1);
        chk(acc, 1'b0);
        @(posedge I_MCLK) begin
            ce <= 1'b1;
            pins <= 3'b011;
        end
        h.bus(1'b1, 4'hC, 32'h4, d);
        @(posedge I_MCLK);
        #1 chk({wacq, wfrm}, 2'b00);
    endtask
    initial begin
        repeat (10) @(posedge I_MCLK);
        I_RESET <= 1'b0;
        t_soft;
        t_hw;
        t_more;
        print_verdict(0);
    end
    initial #100000 print_verdict(1);
endmodule
